// >>> src/tio_sel_pkg.sv
// What this block does
// - channels 0-3 share one 2-bit clock select: codes pick clock bus 0..3
// - channel 4 has a 2-bit clock select picking clock bus 0..3
// - channel 4 external-input enable bit: 0 disables, 1 enables
// - ch3/4 and ch6 enable source: 0X none, 10 event bus 2, 11 event bus 3
// - channels 4,5,6 have 3-bit operating mode fields with eight defined modes
// - channel 4 measure modes capture counter on external capture even if enable is 0
// - channel 4 measure-clear reloads counter to all ones only when enable is 1
// - ch5 clock select: 0XX external pin 1, 1XX clock bus 0..3
// - ch5 enable source: 0X and 10 none, 11 event bus 3
// - ch6 clock select: 0XX external pin 2, 1XX clock bus 0..3
package tio_sel_pkg;
    // printed offsets are not multiples of four: kept as indices, byte addr = 4*index
    localparam logic [31:0] IDX_CH03_CLK = 32'h0080031d;
    localparam logic [31:0] IDX_CH4_CTL  = 32'h0080034a;
    localparam logic [31:0] IDX_CH5_CTL  = 32'h0080034b;
    localparam logic [31:0] IDX_CH6_CTL  = 32'h0080036a;
    localparam logic [7:0]  REG_RESET    = 8'h00;
    // field positions (bit 0 = register lsb)
    localparam int CH03_CKS_LSB = 0;
    localparam int CKS2_LSB     = 0;
    localparam int EEN_BIT      = 2;
    localparam int ENS_LSB      = 3;
    localparam int MODE_LSB     = 5;
    localparam int CKS3_LSB     = 0;
    localparam logic [7:0] CH03_MASK = 8'h03;

    typedef enum logic [2:0] {
        MODE_SINGLE    = 3'b000,
        MODE_DELAYED   = 3'b001,
        MODE_CONT      = 3'b010,
        MODE_PWM       = 3'b011,
        MODE_MEAS_CLR  = 3'b100,
        MODE_MEAS_FREE = 3'b101,
        MODE_NOISE_A   = 3'b110,
        MODE_NOISE_B   = 3'b111
    } op_mode_t;

    // clock choice: bus 0..3 or external pin
    typedef struct packed {
        logic       ext_pin;
        logic [1:0] bus;
    } clk_sel_t;

    // enable/measure source: valid plus event bus number
    typedef struct packed {
        logic       valid;
        logic [1:0] bus;
    } ens_sel_t;

    typedef struct packed {
        logic [1:0] ch03;
        logic [7:0] ch4;
        logic [7:0] ch5;
        logic [7:0] ch6;
        logic [31:0] hrdata;
        logic        rd_pend;
        logic        wr_pend;
        logic [1:0]  wr_sel;
    } state_t;

    typedef struct packed {
        logic capture;
        logic reload;
    } ch4_act_t;
endpackage : tio_sel_pkg

// >>> src/tio_sel_regs.sv
`timescale 1ns/1ps
`default_nettype none
module timer_io_channel_select_regs (
    input  wire logic                  clk_sys,
    input  wire logic                  rstn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire logic                  ch4_ext_capture,
    output tio_sel_pkg::clk_sel_t      ch03_clk,
    output tio_sel_pkg::clk_sel_t      ch4_clk,
    output tio_sel_pkg::clk_sel_t      ch5_clk,
    output tio_sel_pkg::clk_sel_t      ch6_clk,
    output tio_sel_pkg::ens_sel_t      ch34_ens,
    output tio_sel_pkg::ens_sel_t      ch5_ens,
    output tio_sel_pkg::ens_sel_t      ch6_ens,
    output tio_sel_pkg::op_mode_t      ch4_mode,
    output tio_sel_pkg::op_mode_t      ch5_mode,
    output tio_sel_pkg::op_mode_t      ch6_mode,
    output logic                       ch4_ext_enable,
    output tio_sel_pkg::ch4_act_t      ch4_act
);
    import tio_sel_pkg::*;

    state_t     s_r;
    state_t     s_nxt;
    logic       cap_q1_r;
    logic       cap_q2_r;
    logic       cap_q3_r;
    logic       cap_pulse;
    logic [1:0] sel;
    logic       hit;
    logic       meas;
    ch4_act_t   act_r;

    // word address decode; index = byte address / 4
    always_comb begin
        sel = 2'd0;
        hit = 1'b1;
        unique case ({2'b00, haddr[31:2]})
            IDX_CH03_CLK: sel = 2'd0;
            IDX_CH4_CTL:  sel = 2'd1;
            IDX_CH5_CTL:  sel = 2'd2;
            IDX_CH6_CTL:  sel = 2'd3;
            default:      hit = 1'b0;
        endcase
    end

    // bus slave and register file, zero wait states
    always_comb begin
        s_nxt = s_r;
        s_nxt.rd_pend = 1'b0;
        s_nxt.wr_pend = 1'b0;
        if (s_r.wr_pend) begin
            unique case (s_r.wr_sel)
                2'd0: s_nxt.ch03 = hwdata[CH03_CKS_LSB +: 2];
                2'd1: s_nxt.ch4  = hwdata[7:0];
                2'd2: s_nxt.ch5  = hwdata[7:0];
                2'd3: s_nxt.ch6  = hwdata[7:0];
            endcase
        end
        if (hsel && hready && htrans[1]) begin
            // unmapped addresses: writes dropped, reads zero, still OKAY
            s_nxt.wr_pend = hwrite && hit;
            s_nxt.wr_sel  = sel;
            s_nxt.hrdata  = 32'h0000_0000;
            if (!hwrite && hit) begin
                unique case (sel)
                    2'd0: s_nxt.hrdata = {24'h0, REG_RESET | {6'h00, s_nxt.ch03}};
                    2'd1: s_nxt.hrdata = {24'h0, s_nxt.ch4};
                    2'd2: s_nxt.hrdata = {24'h0, s_nxt.ch5};
                    2'd3: s_nxt.hrdata = {24'h0, s_nxt.ch6};
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = s_r.hrdata;

    // clock source decode
    assign ch03_clk = '{ext_pin: 1'b0, bus: s_r.ch03};
    assign ch4_clk  = '{ext_pin: 1'b0, bus: s_r.ch4[CKS2_LSB +: 2]};
    assign ch5_clk  = '{ext_pin: ~s_r.ch5[CKS3_LSB + 2],
                        bus: s_r.ch5[CKS3_LSB +: 2]};
    assign ch6_clk  = '{ext_pin: ~s_r.ch6[CKS3_LSB + 2],
                        bus: s_r.ch6[CKS3_LSB +: 2]};

    // enable source: 0X none, 10 bus 2, 11 bus 3; ch5 picks bus 3 for 11 only
    assign ch34_ens = '{valid: s_r.ch4[ENS_LSB + 1],
                        bus: {1'b1, s_r.ch4[ENS_LSB]}};
    assign ch6_ens  = '{valid: s_r.ch6[ENS_LSB + 1],
                        bus: {1'b1, s_r.ch6[ENS_LSB]}};
    assign ch5_ens  = '{valid: &s_r.ch5[ENS_LSB +: 2], bus: 2'd3};

    assign ch4_mode = op_mode_t'(s_r.ch4[MODE_LSB +: 3]);
    assign ch5_mode = op_mode_t'(s_r.ch5[MODE_LSB +: 3]);
    assign ch6_mode = op_mode_t'(s_r.ch6[MODE_LSB +: 3]);
    assign ch4_ext_enable = s_r.ch4[EEN_BIT];

    // capture pin from outside: two flops before any logic, third for the edge
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cap_q1_r <= 1'b0;
            cap_q2_r <= 1'b0;
            cap_q3_r <= 1'b0;
        end else begin
            cap_q1_r <= ch4_ext_capture;
            cap_q2_r <= cap_q1_r;
            cap_q3_r <= cap_q2_r;
        end
    end

    assign cap_pulse = cap_q2_r & ~cap_q3_r;
    assign meas = (ch4_mode == MODE_MEAS_CLR) || (ch4_mode == MODE_MEAS_FREE);

    // capture ignores the enable bit; reload needs it (software is expected to set it)
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            act_r <= '0;
        end else begin
            act_r.capture <= cap_pulse && meas;
            act_r.reload  <= cap_pulse && (ch4_mode == MODE_MEAS_CLR)
                             && ch4_ext_enable;
        end
    end
    assign ch4_act = act_r;

    a_capture_no_een: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cap_q2_r && !cap_q3_r && meas) |=> act_r.capture)
        else $error("capture missed in measure mode");
    a_reload_needs_een: assert property (@(posedge clk_sys) disable iff (!rstn)
        act_r.reload |-> $past(ch4_ext_enable) && $past(ch4_mode == MODE_MEAS_CLR))
        else $error("reload without enable or outside measure clear");
    a_reload_with_cap: assert property (@(posedge clk_sys) disable iff (!rstn)
        act_r.reload |-> act_r.capture)
        else $error("reload without capture");
    a_ch03_upper_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        (hsel && hready && htrans[1] && !hwrite && haddr[31:2] == IDX_CH03_CLK[29:0])
        |=> (hrdata[31:2] == 30'h0))
        else $error("unused shared clock bits read non-zero");
    a_ch03_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_r.wr_pend && s_r.wr_sel == 2'd0) |=> (ch03_clk.bus == $past(hwdata[1:0])))
        else $error("shared clock select not written");
    a_ch5_ext_pin: assert property (@(posedge clk_sys) disable iff (!rstn)
        ch5_clk.ext_pin == (s_r.ch5[2] == 1'b0))
        else $error("ch5 clock pin decode wrong");
    a_ch6_ext_pin: assert property (@(posedge clk_sys) disable iff (!rstn)
        ch6_clk.ext_pin == (s_r.ch6[2] == 1'b0))
        else $error("ch6 clock pin decode wrong");
    a_ch5_ens_only3: assert property (@(posedge clk_sys) disable iff (!rstn)
        ch5_ens.valid |-> (s_r.ch5[4:3] == 2'b11 && ch5_ens.bus == 2'd3))
        else $error("ch5 enable source decode wrong");
    a_ch34_ens_none: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_r.ch4[4] == 1'b0) |-> !ch34_ens.valid)
        else $error("ch3/4 enable source selected for 0X");
    a_ch4_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_r.wr_pend && s_r.wr_sel == 2'd1) |=> (ch4_mode == op_mode_t'($past(hwdata[7:5]))))
        else $error("ch4 mode not written");

    // channel 4 fields follow the written byte one cycle after the data phase
    a_ch4_clk_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_r.wr_pend && s_r.wr_sel == 2'd1) |=> (ch4_clk.bus == $past(hwdata[1:0])))
        else $error("ch4 clock select not written");
    a_ch4_een_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_r.wr_pend && s_r.wr_sel == 2'd1) |=> (ch4_ext_enable == $past(hwdata[2])))
        else $error("ch4 external enable not written");
    a_ch34_ens_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_r.wr_pend && s_r.wr_sel == 2'd1) |=> (ch34_ens.valid == $past(hwdata[4])
        && (!ch34_ens.valid || ch34_ens.bus == {1'b1, $past(hwdata[3])})))
        else $error("ch3/4 enable source not written");

    // channel 5: pin clock for 0XX, bus clock otherwise; only code 11 picks a source
    a_ch5_clk_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_r.wr_pend && s_r.wr_sel == 2'd2) |=> (ch5_clk.ext_pin == !$past(hwdata[2])
        && (ch5_clk.ext_pin || ch5_clk.bus == $past(hwdata[1:0]))))
        else $error("ch5 clock select not written");
    a_ch5_ens_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_r.wr_pend && s_r.wr_sel == 2'd2) |=> (ch5_ens.valid == ($past(hwdata[4:3]) == 2'b11)))
        else $error("ch5 enable source not written");
    a_ch5_mode_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_r.wr_pend && s_r.wr_sel == 2'd2) |=> (ch5_mode == op_mode_t'($past(hwdata[7:5]))))
        else $error("ch5 mode not written");

    // channel 6: pin clock for 0XX, event bus 2 or 3 for 1X
    a_ch6_clk_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_r.wr_pend && s_r.wr_sel == 2'd3) |=> (ch6_clk.ext_pin == !$past(hwdata[2])
        && (ch6_clk.ext_pin || ch6_clk.bus == $past(hwdata[1:0]))))
        else $error("ch6 clock select not written");
    a_ch6_ens_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_r.wr_pend && s_r.wr_sel == 2'd3) |=> (ch6_ens.valid == $past(hwdata[4])
        && (!ch6_ens.valid || ch6_ens.bus == {1'b1, $past(hwdata[3])})))
        else $error("ch6 enable source not written");
    a_ch6_mode_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_r.wr_pend && s_r.wr_sel == 2'd3) |=> (ch6_mode == op_mode_t'($past(hwdata[7:5]))))
        else $error("ch6 mode not written");

    // shared and channel 4 clocks never come from a pin
    a_ch03_no_pin: assert property (@(posedge clk_sys) disable iff (!rstn)
        !ch03_clk.ext_pin)
        else $error("shared clock select shows a pin");
    a_ch4_no_pin: assert property (@(posedge clk_sys) disable iff (!rstn)
        !ch4_clk.ext_pin)
        else $error("ch4 clock select shows a pin");

    // selected enable sources can only be event bus 2 or 3
    a_ch6_ens_none: assert property (@(posedge clk_sys) disable iff (!rstn)
        (s_r.ch6[4] == 1'b0) |-> !ch6_ens.valid)
        else $error("ch6 enable source selected for 0X");
    a_ch34_ens_bus: assert property (@(posedge clk_sys) disable iff (!rstn)
        ch34_ens.valid |-> ch34_ens.bus[1])
        else $error("ch3/4 enable source below bus 2");
    a_ch6_ens_bus: assert property (@(posedge clk_sys) disable iff (!rstn)
        ch6_ens.valid |-> ch6_ens.bus[1])
        else $error("ch6 enable source below bus 2");

    // no write to a register means its decoded fields stay put
    a_ch03_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(s_r.wr_pend && s_r.wr_sel == 2'd0) |=> $stable(ch03_clk))
        else $error("shared clock select changed without a write");
    a_ch4_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(s_r.wr_pend && s_r.wr_sel == 2'd1) |=> $stable({ch4_clk, ch34_ens, ch4_mode, ch4_ext_enable}))
        else $error("ch4 fields changed without a write");
    a_ch5_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(s_r.wr_pend && s_r.wr_sel == 2'd2) |=> $stable({ch5_clk, ch5_ens, ch5_mode}))
        else $error("ch5 fields changed without a write");
    a_ch6_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        !(s_r.wr_pend && s_r.wr_sel == 2'd3) |=> $stable({ch6_clk, ch6_ens, ch6_mode}))
        else $error("ch6 fields changed without a write");

    // bus side: unmapped words are inert, upper read bits always zero
    a_unmapped_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        (hsel && hready && htrans[1] && !hwrite && !hit) |=> (hrdata == 32'h0000_0000))
        else $error("unmapped read not zero");
    a_unmapped_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        (hsel && hready && htrans[1] && hwrite && !hit) |=> !s_r.wr_pend)
        else $error("unmapped write taken");
    a_read_upper_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        (hsel && hready && htrans[1] && !hwrite) |=> (hrdata[31:8] == 24'h00_0000))
        else $error("read upper bits non-zero");

    // read data mirrors the stored byte when no write lands at the same edge
    a_ch03_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        (hsel && hready && htrans[1] && !hwrite && hit && sel == 2'd0 && !s_r.wr_pend)
        |=> (hrdata[1:0] == $past(ch03_clk.bus)))
        else $error("shared clock select read wrong");
    a_ch4_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        (hsel && hready && htrans[1] && !hwrite && hit && sel == 2'd1 && !s_r.wr_pend)
        |=> (hrdata[7:0] == $past(s_r.ch4)))
        else $error("ch4 register read wrong");
    a_ch5_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        (hsel && hready && htrans[1] && !hwrite && hit && sel == 2'd2 && !s_r.wr_pend)
        |=> (hrdata[7:0] == $past(s_r.ch5)))
        else $error("ch5 register read wrong");
    a_ch6_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        (hsel && hready && htrans[1] && !hwrite && hit && sel == 2'd3 && !s_r.wr_pend)
        |=> (hrdata[7:0] == $past(s_r.ch6)))
        else $error("ch6 register read wrong");

    // capture only in the two measure modes, reload only in clear mode with enable set
    a_capture_only_meas: assert property (@(posedge clk_sys) disable iff (!rstn)
        act_r.capture |-> $past(meas))
        else $error("capture outside measure modes");
    a_capture_one_cycle: assert property (@(posedge clk_sys) disable iff (!rstn)
        act_r.capture |=> !act_r.capture)
        else $error("capture pulse longer than one cycle");
    a_reload_with_een: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cap_q2_r && !cap_q3_r && ch4_mode == MODE_MEAS_CLR && ch4_ext_enable)
        |=> act_r.reload)
        else $error("reload missed in measure clear with enable");
    a_no_reload_free: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cap_q2_r && !cap_q3_r && ch4_mode != MODE_MEAS_CLR) |=> !act_r.reload)
        else $error("reload outside measure clear");
endmodule : timer_io_channel_select_regs
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tio_sel_pkg::*;
    logic        clk_sys, rstn, hsel, hwrite, pin, rd_valid, hreadyout, hresp, een;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    clk_sel_t    c03, c4, c5, c6;
    ens_sel_t    e34, e5, e6;
    op_mode_t    m4, m5, m6;
    ch4_act_t    act;
    int          err_count, cmp_count, seed;
    logic [7:0]  rd_q[$];
    logic [1:0]  act_q[$];
    logic [7:0]  sh[4];
    logic [31:0] idx[4] = '{IDX_CH03_CLK, IDX_CH4_CTL, IDX_CH5_CTL, IDX_CH6_CTL};

    timer_io_channel_select_regs i_timer_io_channel_select_regs (
        .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ch4_ext_capture(pin),
        .ch03_clk(c03), .ch4_clk(c4), .ch5_clk(c5), .ch6_clk(c6), .ch34_ens(e34),
        .ch5_ens(e5), .ch6_ens(e6), .ch4_mode(m4), .ch5_mode(m5), .ch6_mode(m6),
        .ch4_ext_enable(een), .ch4_act(act));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_act(input logic [1:0] got, input logic [1:0] exp);
        cmp_word({30'h0, got}, {30'h0, exp});
    endtask : cmp_act

    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop

    // bounded wait for hready; a hang ends the run
    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            err_count++;
            report_and_stop();
        end
    endtask : wait_ready

    // single transfer; a read leaves its expected byte in the queue
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        input logic [7:0] e);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        rd_valid <= 1'b0;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= d;
        rd_valid <= !w;
        if (!w) rd_q.push_back(e);
        wait_ready();
    endtask : xfer

    task automatic wr(input int r, input logic [31:0] d);
        xfer(1'b1, idx[r] << 2, d, 8'h00);
        sh[r] = (r == 0) ? (d[7:0] & 8'h03) : d[7:0];
    endtask : wr

    // read back every register, then decode the fields by hand
    task automatic check_all;
        for (int i = 0; i < 4; i++) xfer(1'b0, idx[i] << 2, 32'h0, sh[i]);
        #1;
        cmp_word(32'({c03, c4, m4, een, e34.valid, e34.valid ? e34.bus : 2'b00}), 32'({1'b0,
            sh[0][1:0], 1'b0, sh[1][1:0], sh[1][7:5], sh[1][2], sh[1][4],
            sh[1][4] ? {1'b1, sh[1][3]} : 2'b00}));
        cmp_word(32'({c5.ext_pin, c5.ext_pin ? 2'b00 : c5.bus, m5, e5.valid,
            e5.valid ? e5.bus : 2'b11}), 32'({~sh[2][2], sh[2][2] ? sh[2][1:0] : 2'b00,
            sh[2][7:5], &sh[2][4:3], 2'b11}));
        cmp_word(32'({c6.ext_pin, c6.ext_pin ? 2'b00 : c6.bus, m6, e6.valid,
            e6.valid ? e6.bus : 2'b00}), 32'({~sh[3][2], sh[3][2] ? sh[3][1:0] : 2'b00,
            sh[3][7:5], sh[3][4], sh[3][4] ? {1'b1, sh[3][3]} : 2'b00}));
    endtask : check_all

    // capture pulse only in measure modes; reload only for clear mode with enable set
    task automatic cap(input logic [7:0] v);
        wr(1, {24'h0, v}); // mode changes only while the capture pin is idle
        if (v[7:6] == 2'b10) act_q.push_back({1'b1, v[7:5] == 3'b100 && v[2]});
        pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
        cmp_word(32'(act_q.size()), 32'h0);
        act_q.delete();
        $display("test capture %h done", v);
    endtask : cap

    task automatic do_reset;
        rstn <= 1'b0;
        rd_valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        sh = '{default: 8'h00};
    endtask : do_reset

    // watcher: takes the oldest note whenever a result shows
    always @(posedge clk_sys) begin
        if (rd_valid) cmp_word(hrdata, {24'h0, rd_q.pop_front()});
        if (act !== 2'b00) cmp_act(act, act_q.size() > 0 ? act_q.pop_front() : 2'b00);
    end

    initial begin
        seed = 32'hcd36;
        {hsel, haddr, htrans, hwrite, hwdata, pin, rd_valid, rstn} = '0;
        hsize = 3'b010;
        err_count = 0;
        cmp_count = 0;
        do_reset();
        check_all();
        $display("test reset_values done");
        // every field code in every register, noise in the unused upper bits
        for (int v = 0; v < 256; v++) begin
            for (int r = 0; r < 4; r++) wr(r, ($random(seed) & 32'hffffff00) | v);
            check_all();
        end
        $display("test all_codes done");
        for (int k = 0; k < 40; k++) begin
            wr($unsigned($random(seed)) % 4, $random(seed));
            xfer(1'b1, 32'h02000c70, $random(seed), 8'h00);
            check_all();
        end
        xfer(1'b0, 32'h02000c70, 32'h0, 8'h00);
        $display("test random_unmapped done");
        cap(8'h80);
        cap(8'h84);
        cap(8'h64);
        cap(8'hc4);
        cap(8'ha0);
        cap(8'ha4);
        wr(3, 32'h000000ff);
        do_reset();
        check_all();
        $display("test second_reset done");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
